// File: sim/ddrct_asserts.sv
/* Port checker for the DDR3 command timing controller.
   Assumes it is bound into ddrct_ctrl, one clock domain. */
`include "ddrct_consts.vh"
module ddrct_asserts #(parameter integer ROW_W = 14, CWL = 5) (
    input wire logic             i_clk, i_reset, i_req_wr, i_req_ap,
    input wire logic [ROW_W-1:0] i_req_row, o_row,
    input wire logic [1:0]       i_burst,
    input wire logic             i_dll_off, o_req_ack, o_ap, o_cke,
    input wire logic [2:0]       o_cmd,
    input wire logic             o_row_open
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  wr_cnt;  // Cycles since the last write, saturating.
    logic [7:0]  wr_need; // Cycles a precharge must wait after it.
    logic [11:0] ref_cnt; // Cycles since the last refresh.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Fixed BC4 starts recovery two cycles sooner; DLL-off needs 4 clocks.
    always @(posedge i_clk) begin
        if (i_reset) wr_need <= 8'h00;
        else if (o_cmd == `DDRCT_CMD_WR)
            wr_need <= 8'(CWL + (($past(i_dll_off)) ? 4 : 1)
                + (($past(i_burst) == `DDRCT_BURST_BC4_FIX) ? 2 : 4));
        if (i_reset) wr_cnt <= 8'hff;
        else if (o_cmd == `DDRCT_CMD_WR) wr_cnt <= 8'h01;
        else if (wr_cnt != 8'hff) wr_cnt <= wr_cnt + 8'h01;
        if (i_reset || o_cmd == `DDRCT_CMD_REF) ref_cnt <= 12'h000;
        else ref_cnt <= ref_cnt + 12'h001;
    end
    ref_gap_a: assert property (
        o_cmd == `DDRCT_CMD_REF |=> o_cmd != `DDRCT_CMD_REF)
        else $error("refresh commands back to back");
    ref_span_a: assert property (ref_cnt < 12'hdbb)
        else $error("refresh window overrun");
    pd_quiet_a: assert property (!o_cke |-> o_cmd == `DDRCT_CMD_NOP)
        else $error("command while clock enable low");
    ack_cmd_a: assert property (o_req_ack |-> o_cmd ==
        ($past(i_req_wr) ? `DDRCT_CMD_WR : `DDRCT_CMD_RD))
        else $error("accept without matching access");
    ack_row_a: assert property (o_req_ack |-> o_row_open &&
        o_row == $past(i_req_row) && o_ap == $past(i_req_ap))
        else $error("access row or flag wrong");
    act_closed_a: assert property (
        o_cmd == `DDRCT_CMD_ACT |-> !$past(o_row_open) && o_row_open)
        else $error("activate on an open row");
    act_pre_a: assert property (
        o_cmd == `DDRCT_CMD_ACT |=> o_cmd != `DDRCT_CMD_PRE)
        else $error("precharge before row active minimum");
    wr_pre_a: assert property (
        o_cmd == `DDRCT_CMD_PRE |-> wr_cnt >= wr_need)
        else $error("precharge inside write recovery");
    ap_hold_a: assert property (
        o_cmd == `DDRCT_CMD_WR && o_ap |=> o_row_open [*8])
        else $error("auto precharge closed row early");
    cover property (o_cmd == `DDRCT_CMD_WR && o_ap);
    cover property (o_cmd == `DDRCT_CMD_PRE);
    cover property ($fell(o_cke));
endmodule // ddrct_asserts
bind ddrct_ctrl ddrct_asserts #(.ROW_W(ROW_W), .CWL(CWL)) u_chk (.i_clk,
    .i_reset, .i_req_wr, .i_req_ap, .i_req_row, .o_row, .i_burst,
    .i_dll_off, .o_req_ack, .o_ap, .o_cke, .o_cmd, .o_row_open);

// File: sim/ddrct_ctrl_bench.sv
/* Testbench for ddrct_ctrl with a behavioural device on its commands.
   Assumes a 50 MHz clock and a shortened refresh interval. */
`include "ddrct_consts.vh"
module ddrct_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int REFI = 40; // Short refresh interval keeps runs brief.
    logic i_clk = 0, i_reset = 1, i_req = 0, i_req_wr = 0, i_req_ap = 0;
    logic i_dll_off = 0, i_hot = 0, i_pd_req = 0;
    logic [13:0] i_req_row = 14'h0000, o_row;
    logic [1:0]  i_burst = 2'h0;
    logic [2:0]  o_cmd;
    logic [7:0]  viol;
    logic        o_req_ack, o_ap, o_cke, o_row_open;
    int          bad_count = 0, n_checks = 0;
    always #10 i_clk = ~i_clk;
    ddrct_ctrl #(.REFI_CYC(REFI)) DUT (.i_clk, .i_reset, .i_req, .i_req_wr,
        .i_req_row, .i_req_ap, .i_burst, .i_dll_off, .i_hot, .i_pd_req,
        .o_req_ack, .o_cmd, .o_row, .o_ap, .o_cke, .o_row_open);
    ddrct_mem_model u_mem (.i_clk, .i_reset, .i_ap(o_ap), .i_dll_off,
        .i_cmd(o_cmd), .i_burst, .o_viol(viol));
    task automatic check(input logic [15:0] seen, exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // One access held until accepted; act_at is the edge that saw ACT.
    task automatic access(input logic wr, ap, input logic [13:0] row,
                          input logic [1:0] bm, output int act_at);
        int n;
        n = 0;
        act_at = -1;
        i_req <= 1'b1; i_req_wr <= wr; i_req_ap <= ap;
        i_req_row <= row; i_burst <= bm;
        do begin
            @(posedge i_clk);
            n++;
            if (o_cmd === `DDRCT_CMD_ACT && act_at < 0) act_at = n;
        end while (o_req_ack !== 1'b1 && n < 300);
        check(o_cmd, wr ? `DDRCT_CMD_WR : `DDRCT_CMD_RD, "command");
        check({o_row, o_ap}, {row, ap}, "row or flag");
        i_req <= 1'b0;
        @(posedge i_clk);
    endtask
    // Every burst mode, normal and DLL-off, then a row miss read.
    task automatic t_miss;
        int a;
        for (int d = 0; d < 2; d++)
            for (int b = 0; b < 3; b++) begin
                i_dll_off <= d[0];
                access(1, 0, 14'(16 * d + 2 * b), 2'(b), a);
                access(0, 0, 14'(16 * d + 2 * b + 1), 2'(b), a);
                check(a > 0, 1, "no activate after miss");
            end
        i_dll_off <= 1'b0;
    endtask
    // Auto precharge: the next activate waits out recovery and tRP.
    task automatic t_ap;
        int a, lo;
        for (int b = 0; b < 3; b++) begin
            lo = `DDRCT_CWL_CK + ((b == 2) ? 2 : 4) + 2;
            access(1, 1, 14'h0100, 2'(b), a);
            access(0, 0, 14'(b + 257), 2'(b), a);
            check(a + 1 >= lo && a + 1 <= lo + 12, 1, "ap gap");
        end
    endtask
    // Idle refresh count over twenty intervals; doubled when hot.
    task automatic t_ref(input logic hot);
        int n;
        n = 0;
        i_hot <= hot;
        repeat (20) @(posedge i_clk);
        repeat (20 * REFI) begin
            @(posedge i_clk);
            if (o_cmd === `DDRCT_CMD_REF) n++;
        end
        check(n >= (hot ? 39 : 19) && n <= (hot ? 41 : 21), 1, "refs");
    endtask
    // Power-down entry and exit through the clock enable.
    task automatic t_pd;
        int n;
        i_pd_req <= 1'b1;
        for (n = 0; n < 100 && o_cke !== 1'b0; n++) @(posedge i_clk);
        check(o_cke, 0, "no power-down");
        repeat (10) @(posedge i_clk);
        i_pd_req <= 1'b0;
        for (n = 0; n < 100 && o_cke !== 1'b1; n++) @(posedge i_clk);
        check(o_cke, 1, "no power-down exit");
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        check({o_cmd, o_cke, o_row_open, o_req_ack}, 6'h04, "reset");
        t_miss;
        t_ap;
        t_ref(1);
        t_ref(0);
        t_pd;
        check(viol, 0, "device saw illegal command");
        close_out;
    end
    // Tests need under 5000 cycles; 20000 cycles means a hang.
    initial begin
        #400000;
        bad_count++;
        close_out;
    end
endmodule // ddrct_ctrl_bench

// File: sim/ddrct_mem_model.sv
/* Behavioural DDR3 device watching the controller's commands.
   Assumes one bank; an activate or a refresh with a row open bumps o_viol. */
`include "ddrct_consts.vh"
module ddrct_mem_model (
    input  wire logic       i_clk, i_reset, i_ap, i_dll_off,
    input  wire logic [2:0] i_cmd,
    input  wire logic [1:0] i_burst,
    output logic      [7:0] o_viol
);
    timeunit 1ns;
    timeprecision 1ns;
    logic open;      // Row open inside the device.
    int   age, pend; // Cycles since activate; to internal precharge.
    int   rec;       // Write to internal precharge, in cycles.
    assign rec = `DDRCT_CWL_CK + (i_dll_off ? 4 : 1)
        + ((i_burst == `DDRCT_BURST_BC4_FIX) ? 2 : 4);
    // The internal precharge waits for tRAS after a read and for write recovery after a write.
    always @(posedge i_clk) begin
        if (i_reset) begin
            open <= 1'b0; o_viol <= 8'h00; pend <= 0; age <= 0;
        end else begin
            age <= age + 1;
            if (pend == 1) open <= 1'b0;
            if (pend > 0) pend <= pend - 1;
            case (i_cmd)
            `DDRCT_CMD_ACT: begin
                if (open) o_viol <= o_viol + 8'h01;
                open <= 1'b1; age <= 0;
            end
            `DDRCT_CMD_PRE, `DDRCT_CMD_PREA: open <= 1'b0;
            `DDRCT_CMD_WR: if (i_ap) pend <= rec;
            `DDRCT_CMD_RD: if (i_ap) pend <= (age < 2) ? 2 - age : 1;
            `DDRCT_CMD_REF: if (open) o_viol <= o_viol + 8'h01;
            default: ;
            endcase
        end
    end
endmodule // ddrct_mem_model

// File: verilog/ddrct_consts.vh
/*
 * Timing constants for the DDR3 command timing controller.
 * Assumes a 50 MHz controller clock that also paces the command clock.
 */
`ifndef DDRCT_CONSTS_VH
`define DDRCT_CONSTS_VH
// Controller clock period in picoseconds.
`define DDRCT_TCK_PS          20000
// Row precharge time in picoseconds.
`define DDRCT_TRP_PS          15000
// Minimum row active time in picoseconds.
`define DDRCT_TRAS_PS         35000
// Write recovery time in picoseconds.
`define DDRCT_TWR_PS          15000
// Write recovery floor in DLL-disable mode, in clocks.
`define DDRCT_TWR_DLLOFF_CK   4
// Refresh cycle time in picoseconds.
`define DDRCT_TRFC_PS         110000
// Refresh to power-down minimum, in clocks.
`define DDRCT_TREFPDEN_CK     1
// Power-down exit with DLL off, in picoseconds.
`define DDRCT_TXPDLL_PS       24000
// Average refresh interval at or below 85 C, in nanoseconds.
`define DDRCT_TREFI_NS        7812
// Nine-refresh window in nanoseconds.
`define DDRCT_TREF9_NS        70300
// Slow-clock threshold for precharge-all after refresh, in ps.
`define DDRCT_SLOWCK_PS       40000
// Write recovery start offsets after write latency, in clocks.
`define DDRCT_WR_START_BL8    4
`define DDRCT_WR_START_BC4F   2
// Write latency in clocks.
`define DDRCT_CWL_CK          5
// Command encodings on o_cmd.
`define DDRCT_CMD_NOP         3'h0
`define DDRCT_CMD_ACT         3'h1
`define DDRCT_CMD_RD          3'h2
`define DDRCT_CMD_WR          3'h3
`define DDRCT_CMD_PRE         3'h4
`define DDRCT_CMD_REF         3'h5
`define DDRCT_CMD_PREA        3'h6
// Burst modes on i_burst.
`define DDRCT_BURST_BL8       2'h0
`define DDRCT_BURST_BC4_OTF   2'h1
`define DDRCT_BURST_BC4_FIX   2'h2
`endif

// File: verilog/ddrct_ctrl.v
/*
 * DDR3 command timing controller: takes user requests for one bank and
 * issues ACTIVATE, READ, WRITE, PRECHARGE and REFRESH with every timing
 * gap held by counters. Assumes the user holds a request until accepted
 * and that the temperature flag may come from an asynchronous source.
 */
// What this block does, except (R12)
// (R1) Precharge to activate spaced by rounded-up tRP
// (R2) Auto precharge waits for row active minimum
// (R3) DLL-off write recovery is max(4CK,15ns)
// (R4) BL8 and OTF BC4 recovery starts WL+4
// (R5) Fixed BC4 recovery starts at WL+2
// (R6) Refresh every 7.8125 us at normal temperature
// (R7) Nine refreshes within every 70.3 us window
// (R8) Above 85 C refresh interval halves
// (R9) Clock enable low only after tREFPDEN, tXPDLL
// (R10) Keep NOP between back-to-back refreshes
// (R11) Below 25 MHz follow refresh with precharge-all
// (R12) Accesses spread evenly across rows; not done here, each access opens the row it requests
// (R13) Minimums round up, maximums round down
// (R14) Stall scheduler until every timing counter expires
`include "ddrct_consts.vh"
module ddrct_ctrl #(
    parameter integer TCK_PS     = `DDRCT_TCK_PS,
    parameter integer REFI_CYC   = (`DDRCT_TREFI_NS * 1000) / `DDRCT_TCK_PS,
    parameter integer CWL        = `DDRCT_CWL_CK,
    parameter integer ROW_W      = 14
) (
    input  wire             i_clk,
    input  wire             i_reset,
    input  wire             i_req,        // Access request, level.
    input  wire             i_req_wr,     // 1 for write, 0 for read.
    input  wire [ROW_W-1:0] i_req_row,    // Row of the access.
    input  wire             i_req_ap,     // Close row with auto precharge.
    input  wire [1:0]       i_burst,      // Burst mode of the access.
    input  wire             i_dll_off,    // Device runs in DLL-disable mode.
    input  wire             i_hot,        // Case above 85 C (async pin).
    input  wire             i_pd_req,     // Request to enter power-down.
    output reg              o_req_ack,    // One-cycle accept pulse.
    output reg  [2:0]       o_cmd,        // Command issued this cycle.
    output reg  [ROW_W-1:0] o_row,        // Row address with o_cmd.
    output reg              o_ap,         // Auto precharge flag with o_cmd.
    output reg              o_cke,        // Clock enable to the device.
    output reg              o_row_open    // A row is currently open.
);
    // Cycle counts; minimums round up, maximums round down. (R13)
    localparam integer TRP_CYC   = (`DDRCT_TRP_PS + TCK_PS - 1) / TCK_PS;
    localparam integer TRAS_CYC  = (`DDRCT_TRAS_PS + TCK_PS - 1) / TCK_PS;
    localparam integer TWRN_CYC  = (`DDRCT_TWR_PS + TCK_PS - 1) / TCK_PS;
    localparam integer TRFC_CYC  = (`DDRCT_TRFC_PS + TCK_PS - 1) / TCK_PS;
    localparam integer TXPD_CYC  = (`DDRCT_TXPDLL_PS + TCK_PS - 1) / TCK_PS;
    localparam integer R9_CYC    = (`DDRCT_TREF9_NS * 1000) / TCK_PS;
    // DLL-off write recovery takes the larger bound. (R3)
    localparam integer TWRD_CYC  = (TWRN_CYC > `DDRCT_TWR_DLLOFF_CK) ?
                                   TWRN_CYC : `DDRCT_TWR_DLLOFF_CK;
    // Slow clock needs a precharge-all after each refresh. (R11)
    localparam         SLOW_CK   = (TCK_PS > `DDRCT_SLOWCK_PS);
    // A refresh cycle of one clock or less needs a NOP gap. (R10)
    localparam integer REF_GAP   = (TRFC_CYC < 2) ? 2 : TRFC_CYC;
    // Power-down entry wait after refresh. (R9)
    localparam integer PDN_CYC   = (TXPD_CYC > `DDRCT_TREFPDEN_CK) ?
                                   TXPD_CYC : `DDRCT_TREFPDEN_CK;

    // Scheduler states.
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_OPEN = 3'h1;
    localparam [2:0] S_PRE  = 3'h2;
    localparam [2:0] S_REF  = 3'h3;
    localparam [2:0] S_PREA = 3'h4;
    localparam [2:0] S_PD   = 3'h5;

    reg  [2:0]  state;         // Scheduler state.
    reg  [15:0] rp_cnt;        // Precharge to activate timer.
    reg  [15:0] ras_cnt;       // Activate to precharge timer.
    reg  [15:0] wr_cnt;        // Write end plus recovery timer.
    reg  [15:0] rfc_cnt;       // Refresh busy timer.
    reg  [15:0] pdn_cnt;       // Refresh to power-down timer.
    reg  [19:0] refi_cnt;      // Average refresh interval timer.
    reg  [3:0]  ref_owed;      // Refreshes due and not yet issued.
    reg  [19:0] win_cnt;       // Nine-refresh window timer.
    reg  [3:0]  win_refs;      // Refreshes issued in current window.
    reg  [ROW_W-1:0] open_row; // Row held open in the bank.
    reg         hot_meta;      // First synchroniser stage of i_hot.
    reg         hot;           // Synchronised temperature flag.

    // Interval halves when hot; the owed count is capped at nine. (R6) (R8)
    wire [31:0] refi_full = hot ? (REFI_CYC / 2) : REFI_CYC;
    wire [19:0] refi_lim  = refi_full[19:0];
    // Urgent in the last four intervals of a window short of nine refreshes. (R7)
    wire win_late = (win_cnt >= R9_CYC - 4*REFI_CYC) && (win_refs < 4'h9);
    wire ref_due  = (ref_owed != 4'h0) || win_late;
    // Start offset of write recovery depends on burst mode. (R4) (R5)
    wire [31:0] wr_start = (i_burst == `DDRCT_BURST_BC4_FIX) ?
        `DDRCT_WR_START_BC4F : `DDRCT_WR_START_BL8;
    wire [31:0] wr_rec = i_dll_off ? TWRD_CYC : TWRN_CYC;
    // Full-width load values; the timers take their low bits on purpose.
    wire [31:0] wr_total  = CWL + wr_start + wr_rec;
    wire [31:0] trp_full  = TRP_CYC;
    wire [31:0] ras_full  = TRAS_CYC - 1;
    wire [31:0] gap_full  = REF_GAP - 1;
    wire [31:0] pdn_full  = PDN_CYC;
    wire [31:0] txpd_full = TXPD_CYC;
    // Precharge and refresh gating timers expired. (R14)
    wire t_ok = (rp_cnt == 16'h0000) && (rfc_cnt == 16'h0000);

    // Two-flop synchroniser for the temperature pin.
    always @(posedge i_clk) begin
        if (i_reset) begin
            hot_meta <= 1'b0;
            hot      <= 1'b0;
        end else begin
            hot_meta <= i_hot;
            hot      <= hot_meta;
        end
    end

    // Refresh interval and window bookkeeping.
    always @(posedge i_clk) begin
        if (i_reset) begin
            refi_cnt <= 20'h0_0000;
            ref_owed <= 4'h0;
            win_cnt  <= 20'h0_0000;
            win_refs <= 4'h0;
        end else begin
            // A new refresh falls due each interval; issuing pays one.
            if (refi_cnt + 20'h0_0001 >= refi_lim) begin
                refi_cnt <= 20'h0_0000; // (R6)
                if (!(o_cmd == `DDRCT_CMD_REF) && ref_owed != 4'h9)
                    ref_owed <= ref_owed + 4'h1;
            end else begin
                refi_cnt <= refi_cnt + 20'h0_0001;
                if (o_cmd == `DDRCT_CMD_REF && ref_owed != 4'h0)
                    ref_owed <= ref_owed - 4'h1;
            end
            // Window restarts whenever it has seen nine refreshes. (R7)
            if (win_refs >= 4'h9 || win_cnt + 20'h0_0001 >= R9_CYC) begin
                win_cnt  <= 20'h0_0000;
                win_refs <= (o_cmd == `DDRCT_CMD_REF) ? 4'h1 : 4'h0;
            end else begin
                win_cnt <= win_cnt + 20'h0_0001;
                if (o_cmd == `DDRCT_CMD_REF)
                    win_refs <= win_refs + 4'h1;
            end
        end
    end

    // Command scheduler; one command or a NOP every clock.
    always @(posedge i_clk) begin
        if (i_reset) begin
            state      <= S_IDLE;
            rp_cnt     <= 16'h0000;
            ras_cnt    <= 16'h0000;
            wr_cnt     <= 16'h0000;
            rfc_cnt    <= 16'h0000;
            pdn_cnt    <= 16'h0000;
            open_row   <= {ROW_W{1'b0}};
            o_req_ack  <= 1'b0;
            o_cmd      <= `DDRCT_CMD_NOP;
            o_row      <= {ROW_W{1'b0}};
            o_ap       <= 1'b0;
            o_cke      <= 1'b1;
            o_row_open <= 1'b0;
        end else begin
            // Timers count down to zero by default.
            if (rp_cnt  != 16'h0000) rp_cnt  <= rp_cnt  - 16'h0001;
            if (ras_cnt != 16'h0000) ras_cnt <= ras_cnt - 16'h0001;
            if (wr_cnt  != 16'h0000) wr_cnt  <= wr_cnt  - 16'h0001;
            if (rfc_cnt != 16'h0000) rfc_cnt <= rfc_cnt - 16'h0001;
            if (pdn_cnt != 16'h0000) pdn_cnt <= pdn_cnt - 16'h0001;
            o_req_ack <= 1'b0;
            o_cmd     <= `DDRCT_CMD_NOP;
            o_ap      <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (ref_due && t_ok) begin
                        o_cmd   <= `DDRCT_CMD_REF;
                        // At least one NOP before the next refresh. (R10)
                        rfc_cnt <= gap_full[15:0];
                        pdn_cnt <= pdn_full[15:0];
                        state   <= SLOW_CK ? S_PREA : S_IDLE; // (R11)
                    end else if (i_pd_req && t_ok && !ref_due &&
                                 pdn_cnt == 16'h0000) begin
                        o_cke <= 1'b0; // (R9)
                        state <= S_PD;
                    end else if (i_req && t_ok) begin
                        o_cmd      <= `DDRCT_CMD_ACT;
                        o_row      <= i_req_row;
                        open_row   <= i_req_row;
                        ras_cnt    <= ras_full[15:0];
                        o_row_open <= 1'b1;
                        state      <= S_OPEN;
                    end
                end
                S_OPEN: begin
                    // Row hit issues the access; a miss or refresh closes.
                    // The cycle after an accept is skipped: the user still
                    // holds the request then, and it must not run twice.
                    if (o_req_ack) begin
                        state <= S_OPEN;
                    end else if (i_req && i_req_row == open_row &&
                                 !ref_due) begin
                        o_cmd     <= i_req_wr ? `DDRCT_CMD_WR : `DDRCT_CMD_RD;
                        o_row     <= open_row;
                        o_ap      <= i_req_ap;
                        o_req_ack <= 1'b1;
                        if (i_req_wr)
                            wr_cnt <= wr_total[15:0]; // (R4) (R5)
                        // Device delays its own precharge to tRAS. (R2)
                        if (i_req_ap)
                            state <= S_PRE;
                    end else if (i_req || ref_due || i_pd_req) begin
                        state <= S_PRE;
                    end
                end
                S_PRE: begin
                    // Wait tRAS and write recovery before closing. (R14)
                    if (ras_cnt == 16'h0000 && wr_cnt == 16'h0000) begin
                        if (!o_ap && o_cmd != `DDRCT_CMD_RD &&
                            o_cmd != `DDRCT_CMD_WR)
                            o_cmd <= `DDRCT_CMD_PRE;
                        rp_cnt     <= trp_full[15:0]; // (R1)
                        o_row_open <= 1'b0;
                        state      <= S_IDLE;
                    end
                end
                S_PREA: begin
                    if (rfc_cnt == 16'h0000) begin
                        o_cmd  <= `DDRCT_CMD_PREA; // (R11)
                        rp_cnt <= trp_full[15:0];
                        state  <= S_IDLE;
                    end
                end
                S_PD: begin
                    // Leave power-down when released or refresh falls due.
                    if (!i_pd_req || ref_due) begin
                        o_cke   <= 1'b1;
                        rp_cnt  <= txpd_full[15:0]; // (R9)
                        state   <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // ddrct_ctrl
